/* core/sar_adc_serial_readout.sv */
// sequencer for a differential sampling converter behind a 3-wire serial port
`timescale 1ns/1ps
`include "sar_adc_serial_readout_cfg.svh"

module sar_adc_serial_readout #(
	parameter int RESULT_W = `RESULT_WIDTH
) (
	// clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  rstn,
	// serial pins, synchronous to core_clk
	input  wire logic                  selN,
	input  wire logic                  sclk,
	// code from the comparator array, two's complement
	input  wire logic [RESULT_W-1:0]   convCode,
	// serial data output
	output logic                       dout,
	output logic                       doutOe,
	// status of the sampling switch and power domains
	output logic                       acquiring,
	output logic                       analogOn,
	output logic                       digitalOn,
	output logic                       outputOn
);

	// the edge numbers of the sequence are fixed, so only one result width can be served;
	// refused at elaboration rather than at run time
	if (RESULT_W != `RESULT_WIDTH) begin : g_width_check
		$error("sequence edges only serve a 12-bit result");
	end

	sar_adc_serial_readout_pkg::seq_state_t state;
	sar_adc_serial_readout_pkg::seq_state_t next_state;
	sar_adc_serial_readout_pkg::serial_in_t prevIn;
	sar_adc_serial_readout_pkg::serial_in_t next_prevIn;
	sar_adc_serial_readout_pkg::power_t     power;
	sar_adc_serial_readout_pkg::power_t     next_power;
	logic [`EDGE_CNT_WIDTH-1:0]             edgeCnt;
	logic [`EDGE_CNT_WIDTH-1:0]             next_edgeCnt;
	logic [RESULT_W-1:0]                    heldCode;
	logic [RESULT_W-1:0]                    next_heldCode;
	logic                                   next_dout;
	logic                                   next_doutOe;
	logic                                   next_acquiring;
	logic                                   sclkFall;
	logic                                   selFall;
	logic [`EDGE_CNT_WIDTH-1:0]             nextEdge;

	// msb-first index for edges 3..14, lsb-first index for edges 15..25
	function automatic logic [3:0] bitIndex(input logic [`EDGE_CNT_WIDTH-1:0] n);
		logic [`EDGE_CNT_WIDTH-1:0] idx;
		idx = '0;
		if (n <= `EDGE_LSB) begin
			idx = `EDGE_LSB - n;
		end else begin
			idx = n - `EDGE_LSB;
		end
		return idx[3:0];
	endfunction

	assign sclkFall = prevIn.sclk & ~sclk;
	assign selFall  = prevIn.selN & ~selN;
	// counter saturates so stray clocks after the sequence change nothing
	assign nextEdge = (edgeCnt == `EDGE_SAT) ? edgeCnt : edgeCnt + 5'h01;

	// one-cycle events decoded once and shared by the groups of state that use them
	logic                                   activeSeq;
	logic                                   startEv;
	logic                                   stepEv;
	logic                                   holdEv;
	logic                                   shiftEv;
	logic                                   releaseEv;
	logic                                   analogOffEv;

	// states in which a serial-clock fall advances the sequence
	always_comb begin
		activeSeq = 1'b0;
		unique case (state)
			sar_adc_serial_readout_pkg::IDLE: begin
				activeSeq = 1'b0;
			end
			sar_adc_serial_readout_pkg::ACQUIRE: begin
				activeSeq = 1'b1;
			end
			sar_adc_serial_readout_pkg::SHIFT_MSB: begin
				activeSeq = 1'b1;
			end
			sar_adc_serial_readout_pkg::SHIFT_LSB: begin
				activeSeq = 1'b1;
			end
			sar_adc_serial_readout_pkg::DONE: begin
				// the sequence is over; clocks are ignored from here
				activeSeq = 1'b0;
			end
		endcase
	end

	// a restart needs select high first, so only a real fall counts
	assign startEv = ~selN & selFall & (state == sar_adc_serial_readout_pkg::IDLE);

	// a clock fall seen together with the select fall is not counted
	assign stepEv = ~selN & sclkFall & activeSeq;

	assign holdEv = stepEv & (state == sar_adc_serial_readout_pkg::ACQUIRE)
		& (nextEdge == `EDGE_HOLD);

	assign releaseEv = stepEv & (state == sar_adc_serial_readout_pkg::SHIFT_LSB)
		& (nextEdge == `EDGE_RELEASE);

	assign shiftEv = stepEv & ~releaseEv
		& ((state == sar_adc_serial_readout_pkg::SHIFT_MSB)
		| (state == sar_adc_serial_readout_pkg::SHIFT_LSB));

	// the sixteenth-fall power down is already done at the fourteenth, kept for clarity
	assign analogOffEv = stepEv
		& (((state == sar_adc_serial_readout_pkg::SHIFT_MSB) & (nextEdge == `EDGE_PD_FIRST))
		| ((state == sar_adc_serial_readout_pkg::SHIFT_LSB) & (nextEdge == `EDGE_PD_SECOND)));

	// pin history for edge detection
	always_comb begin
		next_prevIn.selN = selN;
		next_prevIn.sclk = sclk;
	end

	// history resets high, so a select held low through reset counts as a select fall
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			prevIn <= '1;
		end else begin
			prevIn <= next_prevIn;
		end
	end

	// sequencer: state and count of clock falls since the select fall
	always_comb begin
		next_state   = state;
		next_edgeCnt = edgeCnt;
		if (selN) begin
			// sequencer parked while select is high
			next_state   = sar_adc_serial_readout_pkg::IDLE;
			next_edgeCnt = '0;
		end else begin
			unique case (state)
				sar_adc_serial_readout_pkg::IDLE: begin
					if (startEv) begin
						next_state   = sar_adc_serial_readout_pkg::ACQUIRE;
						next_edgeCnt = '0;
					end
				end
				sar_adc_serial_readout_pkg::ACQUIRE: begin
					if (stepEv) begin
						next_edgeCnt = nextEdge;
					end
					if (holdEv) begin
						next_state = sar_adc_serial_readout_pkg::SHIFT_MSB;
					end
				end
				sar_adc_serial_readout_pkg::SHIFT_MSB: begin
					if (stepEv) begin
						next_edgeCnt = nextEdge;
					end
					if (stepEv && nextEdge == `EDGE_REPEAT) begin
						next_state = sar_adc_serial_readout_pkg::SHIFT_LSB;
					end
				end
				sar_adc_serial_readout_pkg::SHIFT_LSB: begin
					if (stepEv) begin
						next_edgeCnt = nextEdge;
					end
					if (releaseEv) begin
						next_state = sar_adc_serial_readout_pkg::DONE;
					end
				end
				sar_adc_serial_readout_pkg::DONE: begin
					// stray clocks change nothing until select goes high
					next_edgeCnt = edgeCnt;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			state   <= sar_adc_serial_readout_pkg::IDLE;
			edgeCnt <= '0;
		end else begin
			state   <= next_state;
			edgeCnt <= next_edgeCnt;
		end
	end

	// sampling switch and held code
	always_comb begin
		next_heldCode  = heldCode;
		next_acquiring = acquiring;
		if (selN) begin
			next_acquiring = 1'b0;
		end else if (startEv) begin
			next_acquiring = 1'b1;
		end else if (holdEv) begin
			// code is two's complement as delivered by the array
			next_heldCode  = convCode;
			next_acquiring = 1'b0;
		end
	end

	// the held code survives select high so a late reader of the pins sees no glitch
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			heldCode  <= `CODE_RESET;
			acquiring <= 1'b0;
		end else begin
			heldCode  <= next_heldCode;
			acquiring <= next_acquiring;
		end
	end

	// serial output register and its driver enable
	always_comb begin
		next_dout   = dout;
		next_doutOe = doutOe;
		if (selN) begin
			// a raise by the fifteenth fall also lands here: no repeat
			next_dout   = 1'b0;
			next_doutOe = 1'b0;
		end else if (holdEv) begin
			next_doutOe = 1'b1;
			next_dout   = 1'b0;
		end else if (releaseEv) begin
			next_doutOe = 1'b0;
			next_dout   = 1'b0;
		end else if (shiftEv) begin
			// each bit goes out as soon as it is decided
			next_dout = heldCode[bitIndex(nextEdge)];
		end else if (state == sar_adc_serial_readout_pkg::DONE) begin
			next_doutOe = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			dout   <= 1'b0;
			doutOe <= 1'b0;
		end else begin
			dout   <= next_dout;
			doutOe <= next_doutOe;
		end
	end

	// power domains
	always_comb begin
		next_power = power;
		if (selN) begin
			// full power down only while select is high
			next_power.analogOn  = 1'b0;
			next_power.digitalOn = 1'b0;
			next_power.outputOn  = 1'b0;
		end else if (startEv) begin
			next_power.analogOn  = 1'b1;
			next_power.digitalOn = 1'b1;
			next_power.outputOn  = 1'b1;
		end else begin
			if (analogOffEv) begin
				// burst: the digital path stays up from here, the output path until the release edge
				next_power.analogOn = 1'b0;
			end
			if (releaseEv) begin
				next_power.outputOn = 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			power <= '0;
		end else begin
			power <= next_power;
		end
	end

	// each power output is a bit of the power register
	assign analogOn  = power.analogOn;
	assign digitalOn = power.digitalOn;
	assign outputOn  = power.outputOn;

endmodule

/* core/sar_adc_serial_readout_cfg.svh */
// timing and sequence constants of the serial readout sequencer
`ifndef SAR_ADC_SERIAL_READOUT_CFG_SVH
`define SAR_ADC_SERIAL_READOUT_CFG_SVH

`define RESULT_WIDTH   12
`define EDGE_CNT_WIDTH 5
// falling serial-clock edges counted from the select fall
`define EDGE_HOLD      5'h02
`define EDGE_MSB       5'h03
`define EDGE_LSB       5'h0E
`define EDGE_PD_FIRST  5'h0E
`define EDGE_PD_SECOND 5'h10
`define EDGE_REPEAT    5'h0F
`define EDGE_LAST      5'h19
`define EDGE_RELEASE   5'h1A
`define EDGE_SAT       5'h1F
// reset value of the held code
`define CODE_RESET     12'h000

`endif

/* core/sar_adc_serial_readout_pkg.sv */
// types shared by the serial readout sequencer
package sar_adc_serial_readout_pkg;

	typedef enum logic [2:0] {
		IDLE,
		ACQUIRE,
		SHIFT_MSB,
		SHIFT_LSB,
		DONE
	} seq_state_t;

	typedef struct packed {
		logic selN;
		logic sclk;
	} serial_in_t;

	typedef struct packed {
		logic analogOn;
		logic digitalOn;
		logic outputOn;
	} power_t;

endpackage

/* tb/readout_monitor.sv */
// checker of the readout sequencer ports
`timescale 1ns/1ps
module readout_monitor (
	// clock, reset and pins
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic selN,
	input wire logic sclk,
	// outputs
	input wire logic dout,
	input wire logic doutOe,
	input wire logic acquiring,
	input wire logic analogOn,
	input wire logic digitalOn,
	input wire logic outputOn
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	idle_off_a: assert property (selN |=> !digitalOn && !outputOn) else $error("up in idle");
	start_a: assert property ($fell(selN) |=> acquiring && analogOn) else $error("no start");
	restart_a: assert property ($rose(digitalOn) |-> $past(selN, 2)) else $error("bad start");
	null_bit_a: assert property ($fell(acquiring) && digitalOn |-> doutOe && !dout)
		else $error("no null bit");
	oe_hold_a: assert property ($rose(doutOe) |-> $fell(acquiring)) else $error("bad enable");
	fall_bit_a: assert property ($changed(dout) && doutOe |-> $past(sclk, 2) && !$past(sclk))
		else $error("bit off a fall");
	analog_off_a: assert property ($fell(analogOn) |->
		!digitalOn || $past(sclk, 2) && !$past(sclk)) else $error("analog off early");
	out_dom_a: assert property (outputOn |-> digitalOn) else $error("output alone");
	cover property ($fell(analogOn) && digitalOn);
	cover property ($fell(doutOe) && digitalOn);
	cover property ($fell(doutOe) && !digitalOn);
endmodule
bind sar_adc_serial_readout readout_monitor mon (.*);

/* tb/host_model.sv */
// host controller model: drives select and serial clock, takes the data
`timescale 1ns/1ps
module host_model (
	// clock and data
	input  wire logic core_clk,
	input  wire logic dout,
	input  wire logic doutOe,
	// serial controls
	output logic      selN,
	output logic      sclk
);
	logic capBit [0:31], capOe [0:31];
	int   nFall;
	initial begin
		selN = 1'b1;
		sclk = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic sel(input logic v);
		selN = v;
		nFall = 0;
		tick(2);
	endtask
	task automatic falls(input int n);
		repeat (n) begin
			sclk = 1'b1;
			tick(2);
			sclk = 1'b0;
			tick(2);
			nFall++;
			capBit[nFall] = dout;
			capOe[nFall] = doutOe;
		end
	endtask
endmodule

/* tb/tb_sar_adc_serial_readout.sv */
// self-checking testbench of the serial readout sequencer
`timescale 1ns/1ps
module tb_sar_adc_serial_readout;
	logic        core_clk, rstn, selN, sclk, dout, doutOe;
	logic        acquiring, analogOn, digitalOn, outputOn;
	logic [11:0] convCode, codes [4] = '{12'h7FF, 12'h000, 12'hFFF, 12'h800};
	initial core_clk = 1'b0;
	int          n_fail = 0, samples_checked = 0;
	always #50 core_clk = ~core_clk;
	sar_adc_serial_readout dut (.*);
	host_model host (.*);
	task automatic check(input logic ok, input string msg);
		samples_checked++;
		n_fail += int'(ok !== 1'b1);
		if (ok !== 1'b1) $display("mismatch %0t %s", $time, msg);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// the code moves after the hold edge, so an unheld code would show up
	task automatic full_frame(input logic [11:0] code);
		convCode = code;
		host.sel(1'b0);
		host.falls(2);
		convCode = ~code;
		host.falls(28);
		for (int i = 2; i <= 30; i++) begin
			check(host.capOe[i] === (i < 26) &&
				(i > 25 || host.capBit[i] === (i == 2 ? 1'b0 : code[i < 15 ? 14 - i : i - 14])), "bit");
		end
		check(analogOn === 1'b0 && digitalOn === 1'b1 && outputOn === 1'b0, "power");
		host.sel(1'b1);
		$display("full frame %h done", code);
	endtask
	task automatic short_frame();
		host.sel(1'b0);
		host.falls(14);
		host.sel(1'b1);
		check(host.capBit[14] === convCode[0] && doutOe === 1'b0, "short");
		$display("short frame done");
	endtask
	initial begin
		rstn = 1'b0;
		convCode = 12'h000;
		host.tick(6);
		rstn = 1'b1;
		foreach (codes[i]) full_frame(codes[i]);
		short_frame();
		stop_test();
	end
	initial begin
		#1000000 n_fail++;
		stop_test();
	end
endmodule
